// File: rtl/port_ctrl_pkg.sv
// constants and carrier types of the port pin function control block
// assumes a 32-bit APB slave window at the port control base address
package port_ctrl_pkg;
    localparam int NUM_PORTS = 7;
    localparam int PINS = 16;
    localparam logic [31:0] PCU_BASE = 32'h4000_1000;
    localparam logic [31:0] LAST_PORT_BASE = 32'h4000_1600;
    localparam logic [31:0] WINDOW_SIZE = 32'h0000_2000;
    localparam logic [3:0] PORT_COUNT = 4'h7;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;

    // register offsets inside one port, and the unlock offset in the window
    localparam logic [7:0] OFS_FSEL_LO = 8'h00;
    localparam logic [7:0] OFS_FSEL_HI = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_PULL = 8'h0c;
    localparam logic [7:0] OFS_DEBOUNCE = 8'h10;
    localparam logic [7:0] OFS_STRENGTH = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MODE = 8'h28;
    localparam logic [7:0] OFS_OUT = 8'h30;
    localparam logic [7:0] OFS_IN = 8'h34;
    localparam logic [7:0] OFS_SET_CLR = 8'h38;
    localparam logic [7:0] OFS_CLR = 8'h3c;
    localparam logic [12:0] OFS_UNLOCK = 13'h1ff0;

    // reset values and selector write and lock masks
    localparam logic [31:0] FSEL_RST = 32'h7777_7777;
    localparam logic [31:0] PC_FSEL_LO_RST = 32'h7773_3333;
    localparam logic [31:0] PC_FSEL_HI_RST = 32'h7777_3377;
    localparam logic [31:0] MODE_RST = 32'hffff_ffff;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    localparam logic [31:0] FSEL_USED_MASK = 32'h7777_7777;
    localparam logic [31:0] PC_HI_LOCK_MASK = 32'h00ff_0000;
    localparam logic [31:0] PD_LO_LOCK_MASK = 32'h0000_00ff;

    // selector, pin mode and interrupt codes
    localparam logic [2:0] FSEL_GPIO = 3'h0;
    localparam logic [2:0] FSEL_F3 = 3'h3;
    localparam logic [2:0] FSEL_F4 = 3'h7;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h0;
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] MODE_INPUT = 2'h3;
    localparam logic [1:0] IRQ_EN_EDGE = 2'h3;
    localparam logic [1:0] IRQ_BOTH = 2'h3;

    typedef struct packed {
        logic [31:0] pull;
        logic [15:0] debounce;
        logic [15:0] strength;
    } port_cfg_type;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_type;
endpackage : port_ctrl_pkg

// File: rtl/port_pin_function_control.sv
// register bank and pin control for seven 16-pin general purpose ports
// assumes APB master on clk_sys; pins asynchronous; clock unit same clock
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module port_pin_function_control (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic crystal_is_sysclk,
    input wire logic [6:0][15:0] pin_in,
    output logic [6:0][15:0] pin_out,
    output logic [6:0][15:0] pin_oe,
    output logic [6:0][15:0][2:0] func_sel,
    output port_ctrl_pkg::port_cfg_type port_cfg [port_ctrl_pkg::NUM_PORTS],
    output logic irq
);
    port_ctrl_pkg::apb_req_type req;
    logic [31:0] rel;
    logic [7:0] ofs;
    logic [2:0] port_idx;
    logic port_hit;
    logic unlock_hit;
    logic ofs_valid;
    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] rd_val [port_ctrl_pkg::NUM_PORTS];
    logic [6:0] irq_port;
    logic [31:0] unlock_q;
    logic [31:0] unlock_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    // address decode over the whole port window
    always_comb begin
        req.addr = paddr;
        req.write = pwrite;
        req.wdata = pwdata;
        rel = req.addr - port_ctrl_pkg::PCU_BASE;
        ofs = rel[7:0];
        port_idx = rel[10:8];
        port_hit = (rel < port_ctrl_pkg::WINDOW_SIZE) && (rel[12] == 1'b0)
            && (rel[11:8] < port_ctrl_pkg::PORT_COUNT);
        unlock_hit = (rel < port_ctrl_pkg::WINDOW_SIZE)
            && (rel[12:0] == port_ctrl_pkg::OFS_UNLOCK);
        case (ofs)
            port_ctrl_pkg::OFS_FSEL_LO,
            port_ctrl_pkg::OFS_FSEL_HI,
            port_ctrl_pkg::OFS_MODE,
            port_ctrl_pkg::OFS_PULL,
            port_ctrl_pkg::OFS_DEBOUNCE,
            port_ctrl_pkg::OFS_STRENGTH,
            port_ctrl_pkg::OFS_IRQ_EN,
            port_ctrl_pkg::OFS_IRQ_STAT,
            port_ctrl_pkg::OFS_IRQ_MODE,
            port_ctrl_pkg::OFS_OUT,
            port_ctrl_pkg::OFS_IN,
            port_ctrl_pkg::OFS_SET_CLR,
            port_ctrl_pkg::OFS_CLR: ofs_valid = 1'b1;
            default: ofs_valid = 1'b0;
        endcase
        setup = psel && !penable;
        wr_acc = psel && penable && req.write;
        rd_acc = psel && penable && !req.write;
    end

    genvar gi;
    generate
        for (gi = 0; gi < port_ctrl_pkg::NUM_PORTS; gi++) begin : g_port
            localparam logic [31:0] LO_RST =
                (gi == int'(port_ctrl_pkg::PORT_C))
                ? port_ctrl_pkg::PC_FSEL_LO_RST
                : port_ctrl_pkg::FSEL_RST;
            localparam logic [31:0] HI_RST =
                (gi == int'(port_ctrl_pkg::PORT_C))
                ? port_ctrl_pkg::PC_FSEL_HI_RST
                : port_ctrl_pkg::FSEL_RST;
            localparam logic [31:0] LO_LOCK =
                (gi == int'(port_ctrl_pkg::PORT_D))
                ? port_ctrl_pkg::PD_LO_LOCK_MASK : 32'h0000_0000;
            localparam logic [31:0] HI_LOCK =
                (gi == int'(port_ctrl_pkg::PORT_C))
                ? port_ctrl_pkg::PC_HI_LOCK_MASK : 32'h0000_0000;

            logic [31:0] fsel_lo_q, fsel_lo_d;
            logic [31:0] fsel_hi_q, fsel_hi_d;
            logic [31:0] mode_q, mode_d;
            logic [31:0] pull_q, pull_d;
            logic [15:0] deb_q, deb_d;
            logic [15:0] str_q, str_d;
            logic [31:0] ien_q, ien_d;
            logic [31:0] ist_q, ist_d;
            logic [31:0] imode_q, imode_d;
            logic [15:0] odr_q, odr_d;
            logic [15:0] sync1_q, sync2_q, prev_q;
            logic [31:0] lock;
            logic [31:0] new_sel;
            logic [31:0] ev;
            logic [31:0] clr;
            logic [31:0] mask;
            logic wr;
            logic rd_stat;
            logic [2:0] sel;
            logic [1:0] md;
            // selector seen by the pin drive, apart from the write path
            logic [2:0] out_sel;

            always_comb begin
                wr = wr_acc && port_hit && (port_idx == 3'(gi));
                rd_stat = rd_acc && port_hit && (port_idx == 3'(gi))
                    && (ofs == port_ctrl_pkg::OFS_IRQ_STAT);
                fsel_lo_d = fsel_lo_q;
                fsel_hi_d = fsel_hi_q;
                mode_d = mode_q;
                pull_d = pull_q;
                deb_d = deb_q;
                str_d = str_q;
                ien_d = ien_q;
                imode_d = imode_q;
                odr_d = odr_q;
                new_sel = req.wdata & port_ctrl_pkg::FSEL_USED_MASK;
                lock = 32'h0000_0000;
                clr = 32'h0000_0000;
                if (wr) begin
                    case (ofs)
                        port_ctrl_pkg::OFS_FSEL_LO: begin
                            lock = crystal_is_sysclk ? LO_LOCK : 32'h0;
                            fsel_lo_d = (new_sel & ~lock)
                                | (fsel_lo_q & lock);
                        end
                        port_ctrl_pkg::OFS_FSEL_HI: begin
                            lock = crystal_is_sysclk ? HI_LOCK : 32'h0;
                            fsel_hi_d = (new_sel & ~lock)
                                | (fsel_hi_q & lock);
                        end
                        port_ctrl_pkg::OFS_MODE:
                            mode_d = req.wdata;
                        port_ctrl_pkg::OFS_PULL:
                            pull_d = req.wdata;
                        port_ctrl_pkg::OFS_DEBOUNCE: deb_d = req.wdata[15:0];
                        port_ctrl_pkg::OFS_STRENGTH: str_d = req.wdata[15:0];
                        port_ctrl_pkg::OFS_IRQ_EN:
                            ien_d = req.wdata;
                        port_ctrl_pkg::OFS_IRQ_MODE: imode_d = req.wdata;
                        port_ctrl_pkg::OFS_OUT: odr_d = req.wdata[15:0];
                        port_ctrl_pkg::OFS_IRQ_STAT: clr = req.wdata;
                        // low half sets, high half clears; clear wins
                        port_ctrl_pkg::OFS_SET_CLR:
                            odr_d = (odr_q | req.wdata[15:0])
                                & ~req.wdata[31:16];
                        port_ctrl_pkg::OFS_CLR:
                            odr_d = odr_q & ~req.wdata[15:0];
                        default: odr_d = odr_q;
                    endcase
                end
                // accepted selector writes set mode: function 7 input, 1 to 3 push-pull, others keep it
                for (int p = 0; p < port_ctrl_pkg::PINS; p++) begin
                    sel = (p < 8) ? fsel_lo_d[4*(p%8) +: 3]
                        : fsel_hi_d[4*(p%8) +: 3];
                    if (wr && (((p < 8) && (ofs == port_ctrl_pkg::OFS_FSEL_LO)
                        && !lock[4*(p%8)])
                        || ((p >= 8) && (ofs == port_ctrl_pkg::OFS_FSEL_HI)
                        && !lock[4*(p%8)]))) begin
                        if (sel == port_ctrl_pkg::FSEL_F4) begin
                            mode_d[2*p +: 2] =
                                port_ctrl_pkg::MODE_INPUT;
                        end else if ((sel != port_ctrl_pkg::FSEL_GPIO)
                            && (sel <= port_ctrl_pkg::FSEL_F3)) begin
                            mode_d[2*p +: 2] =
                                port_ctrl_pkg::MODE_PUSH_PULL;
                        end
                    end
                end
                // pin events: edge or level per enable and mode fields
                for (int p = 0; p < port_ctrl_pkg::PINS; p++) begin
                    if (ien_q[2*p +: 2] == port_ctrl_pkg::IRQ_EN_EDGE) begin
                        ev[2*p+1] = imode_q[2*p+1] & sync2_q[p] & ~prev_q[p];
                        ev[2*p] = imode_q[2*p] & ~sync2_q[p] & prev_q[p];
                    end else if ((ien_q[2*p +: 2] != 2'h0)
                        && (imode_q[2*p +: 2]
                        != port_ctrl_pkg::IRQ_BOTH)) begin
                        ev[2*p+1] = imode_q[2*p+1] & sync2_q[p];
                        ev[2*p] = imode_q[2*p] & ~sync2_q[p];
                    end else begin
                        ev[2*p +: 2] = 2'h0;
                    end
                    mask[2*p +: 2] = {2{ien_q[2*p +: 2] != 2'h0}};
                end
                if (rd_stat) begin
                    clr = 32'hffff_ffff;
                end
                ist_d = (ist_q & ~clr) | ev;
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    fsel_lo_q <= LO_RST;
                    fsel_hi_q <= HI_RST;
                    mode_q <= port_ctrl_pkg::MODE_RST;
                    pull_q <= port_ctrl_pkg::ZERO_RST;
                    deb_q <= 16'h0000;
                    str_q <= 16'h0000;
                    ien_q <= port_ctrl_pkg::ZERO_RST;
                    ist_q <= port_ctrl_pkg::ZERO_RST;
                    imode_q <= port_ctrl_pkg::ZERO_RST;
                    odr_q <= 16'h0000;
                    sync1_q <= 16'h0000;
                    sync2_q <= 16'h0000;
                    prev_q <= 16'h0000;
                end else if (clk_en) begin
                    fsel_lo_q <= fsel_lo_d;
                    fsel_hi_q <= fsel_hi_d;
                    mode_q <= mode_d;
                    pull_q <= pull_d;
                    deb_q <= deb_d;
                    str_q <= str_d;
                    ien_q <= ien_d;
                    ist_q <= ist_d;
                    imode_q <= imode_d;
                    odr_q <= odr_d;
                    sync1_q <= pin_in[gi];
                    sync2_q <= sync1_q;
                    prev_q <= sync2_q;
                end
            end

            always_comb begin
                case (ofs)
                    port_ctrl_pkg::OFS_FSEL_LO: rd_val[gi] = fsel_lo_q;
                    port_ctrl_pkg::OFS_FSEL_HI: rd_val[gi] = fsel_hi_q;
                    port_ctrl_pkg::OFS_MODE: rd_val[gi] = mode_q;
                    port_ctrl_pkg::OFS_PULL: rd_val[gi] = pull_q;
                    port_ctrl_pkg::OFS_DEBOUNCE: rd_val[gi] = {16'h0, deb_q};
                    port_ctrl_pkg::OFS_STRENGTH: rd_val[gi] = {16'h0, str_q};
                    port_ctrl_pkg::OFS_IRQ_EN: rd_val[gi] = ien_q;
                    port_ctrl_pkg::OFS_IRQ_STAT: rd_val[gi] = ist_q;
                    port_ctrl_pkg::OFS_IRQ_MODE: rd_val[gi] = imode_q;
                    port_ctrl_pkg::OFS_OUT: rd_val[gi] = {16'h0, odr_q};
                    port_ctrl_pkg::OFS_IN:
                        rd_val[gi] = {16'h0, sync2_q};
                    default: rd_val[gi] = 32'h0000_0000;
                endcase
            end

            // gpio drive only when the pin selects function 0
            always_comb begin
                for (int p = 0; p < port_ctrl_pkg::PINS; p++) begin
                    out_sel = (p < 8) ? fsel_lo_q[4*(p%8) +: 3]
                        : fsel_hi_q[4*(p%8) +: 3];
                    md = mode_q[2*p +: 2];
                    func_sel[gi][p] = out_sel;
                    pin_out[gi][p] = 1'b0;
                    pin_oe[gi][p] = 1'b0;
                    if (out_sel == port_ctrl_pkg::FSEL_GPIO) begin
                        if (md == port_ctrl_pkg::MODE_PUSH_PULL) begin
                            pin_out[gi][p] = odr_q[p];
                            pin_oe[gi][p] = 1'b1;
                        end else if (md
                            == port_ctrl_pkg::MODE_OPEN_DRAIN) begin
                            pin_oe[gi][p] = ~odr_q[p];
                        end
                    end
                end
            end

            assign port_cfg[gi].pull = pull_q;
            assign port_cfg[gi].debounce = deb_q;
            assign port_cfg[gi].strength = str_q;
            assign irq_port[gi] = |(ist_q & mask);
        end
    endgenerate

    // bus side: answer sampled in setup, presented in access phase
    always_comb begin
        unlock_d = unlock_q;
        if (wr_acc && unlock_hit) begin
            unlock_d = req.wdata;
        end
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            pslverr_d = !(unlock_hit || (port_hit && ofs_valid));
            if (unlock_hit) begin
                prdata_d = unlock_q;
            end else if (port_hit) begin
                prdata_d = rd_val[port_idx];
            end else begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            unlock_q <= port_ctrl_pkg::ZERO_RST;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            unlock_q <= unlock_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;
    assign irq = |irq_port;
endmodule : port_pin_function_control

// File: sim/port_ctrl_asserts.sv
// checker on the apb and pin ports of the port control block
// assumes binding into port_pin_function_control, single clock domain
`timescale 1ns/1ps
module port_ctrl_asserts (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic crystal_is_sysclk,
    input wire logic [6:0][15:0] pin_oe,
    input wire logic [6:0][15:0][2:0] func_sel
);
    logic setup_rd;
    logic in_ports;
    logic [6:0][15:0] bad_oe;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    assign setup_rd = psel && !penable && !pwrite && clk_en;
    assign in_ports = paddr[31:12] == 20'h40001 && paddr[11:8] < 4'h7;
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            for (int i = 0; i < 16; i++) begin
                bad_oe[p][i] = pin_oe[p][i] && func_sel[p][i] != 3'h0;
            end
        end
    end
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_fsel_reserved: assert property (setup_rd && in_ports
        && paddr[7:0] inside {8'h00, 8'h04} |=> (prdata & 32'h8888_8888) == 0)
        else $error("reserved selector bits read nonzero");
    a_wo_read_zero: assert property (setup_rd && in_ports
        && paddr[7:0] inside {8'h38, 8'h3c} |=> prdata == 32'h0)
        else $error("write-only register read nonzero");
    a_lock_hold: assert property (crystal_is_sysclk |=>
        $stable(func_sel[2][13:12]) && $stable(func_sel[3][1:0]))
        else $error("protected selector changed under crystal clock");
    a_range_err: assert property (psel && !penable && clk_en
        && (paddr < 32'h4000_1000 || paddr >= 32'h4000_3000) |=> pslverr)
        else $error("no error for address outside window");
    a_mapped_ok: assert property (psel && !penable && clk_en
        && in_ports && paddr[7:0] == 8'h00 |=> !pslverr)
        else $error("error on mapped selector register");
    a_oe_func0: assert property (bad_oe == '0)
        else $error("pin driven while another function selected");
    a_reset_state: assert property (!$past(rst_b)
        |-> pin_oe == '0
        && func_sel[0][0] == 3'h7 && func_sel[2][0] == 3'h3)
        else $error("pin state wrong after reset");
    a_fsel_write: assert property (psel && penable && pwrite && clk_en
        && paddr == 32'h4000_1000 |=> func_sel[0][0] == $past(pwdata[2:0])
        && func_sel[0][7] == $past(pwdata[30:28]))
        else $error("selector write not reflected");
endmodule : port_ctrl_asserts

// File: sim/pin_model.sv
// external pins: loop the driven level back, else an outside source level
// assumes the bench commands the outside source per pin
`timescale 1ns/1ps
module pin_model (
    input wire logic [6:0][15:0] pin_out,
    input wire logic [6:0][15:0] pin_oe,
    input wire logic [6:0][15:0] ext_level,
    output logic [6:0][15:0] pin_in
);
    // outside source yields while the device drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_model

// File: sim/tb.sv
// self-checking bench for the port control block over apb
// assumes 50 MHz clk_sys, clk_en high except in one freeze check
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic crystal_is_sysclk = 1'b0;
    logic clk_en = 1'b1;
    logic pready, pslverr, irq;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd, e;
    logic [31:0] lf = 32'h0000_004c;
    logic [15:0] v;
    logic [6:0][15:0] pin_in, pin_out, pin_oe, ext_level = '0;
    logic [6:0][15:0][2:0] func_sel;
    port_ctrl_pkg::port_cfg_type port_cfg [port_ctrl_pkg::NUM_PORTS];
    logic [12:0] zo [10] = '{13'h0c, 13'h10, 13'h14, 13'h20, 13'h24,
        13'h28, 13'h30, 13'h34, 13'h38, 13'h3c};
    logic [12:0] rwo [6] = '{13'h0c, 13'h20, 13'h28, 13'h10, 13'h14, 13'h30};
    logic [31:0] bad_addr [4] = '{32'h4000_1018, 32'h4000_1700,
        32'h3fff_fffc, 32'h4000_3000};
    int bad_count = 0, check_count = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    port_pin_function_control dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .crystal_is_sysclk(crystal_is_sysclk),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .func_sel(func_sel), .port_cfg(port_cfg), .irq(irq));
    pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .pin_in(pin_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] pa(input int p, input logic [12:0] o);
        return 32'h4000_1000 + 32'(p) * 32'h100 + 32'(o);
    endfunction : pa
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    task test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int p = 0; p < 7; p++) begin
            e = p == 2 ? 32'h7773_3333 : 32'h7777_7777;
            rdc(pa(p, 0), e);
            rdc(pa(p, 4), p == 2 ? 32'h7777_3377 : 32'h7777_7777);
            rdc(pa(p, 8), 32'hffff_ffff);
            foreach (zo[k]) rdc(pa(p, zo[k]), 32'h0);
        end
        $display("reset values done");
        rdc(32'h4000_2ff0, 32'h0);
        lf = lfsr(lf);
        apb(1'b1, 32'h4000_2ff0, lf);
        rdc(32'h4000_2ff0, lf);
        foreach (bad_addr[k]) begin
            apb(1'b0, bad_addr[k], 32'h0);
            check({31'h0, err}, 32'h1);
            check(rd, 32'h0);
        end
        lf = lfsr(lf);
        ext_level[4] <= lf[15:0];
        apb(1'b1, pa(4, 13'h34), ~lf);
        repeat (3) @(posedge clk_sys);
        rdc(pa(4, 13'h34), {16'h0, lf[15:0]});
        $display("bus and input done");
        for (int p = 0; p < 7; p++) begin
            foreach (rwo[k]) begin
                lf = lfsr(lf);
                e = k < 3 ? lf : {16'h0, lf[15:0]};
                apb(1'b1, pa(p, rwo[k]), e);
                rdc(pa(p, rwo[k]), e);
                case (rwo[k])
                    13'h0c: check(port_cfg[p].pull, e);
                    13'h10: check({16'h0, port_cfg[p].debounce}, e);
                    13'h14: check({16'h0, port_cfg[p].strength}, e);
                    default: ;
                endcase
            end
            apb(1'b1, pa(p, 13'h20), 32'h0);
            for (int h = 0; h < 2; h++) begin
                lf = lfsr(lf);
                apb(1'b1, pa(p, 13'(4 * h)), lf);
                e = lf & 32'h7777_7777;
                rdc(pa(p, 13'(4 * h)), e);
                apb(1'b1, pa(p, 13'(4 * h)), 32'h7777_7777);
            end
        end
        $display("read-write done");
        apb(1'b1, pa(5, 0), 32'h0);
        apb(1'b1, pa(5, 4), 32'h0);
        apb(1'b1, pa(5, 8), 32'h0);
        lf = lfsr(lf);
        v = lf[15:0];
        apb(1'b1, pa(5, 13'h30), {16'h0, v});
        @(negedge clk_sys);
        check({16'h0, pin_out[5]}, {16'h0, v});
        check({16'h0, pin_oe[5]}, 32'h0000_ffff);
        repeat (3) @(posedge clk_sys);
        rdc(pa(5, 13'h34), {16'h0, v});
        lf = lfsr(lf);
        apb(1'b1, pa(5, 13'h38), lf);
        v = (v | lf[15:0]) & ~lf[31:16];
        rdc(pa(5, 13'h30), {16'h0, v});
        lf = lfsr(lf);
        apb(1'b1, pa(5, 13'h3c), lf);
        v = v & ~lf[15:0];
        rdc(pa(5, 13'h30), {16'h0, v});
        apb(1'b1, pa(5, 8), 32'h5555_5555);
        @(negedge clk_sys);
        check({16'h0, pin_oe[5]}, {16'h0, ~v});
        $display("output done");
        crystal_is_sysclk <= 1'b1;
        apb(1'b1, pa(2, 4), 32'h0);
        rdc(pa(2, 4), 32'h0077_0000);
        apb(1'b1, pa(3, 0), 32'h0);
        rdc(pa(3, 0), 32'h0000_0077);
        crystal_is_sysclk <= 1'b0;
        apb(1'b1, pa(2, 4), 32'h0);
        rdc(pa(2, 4), 32'h0);
        apb(1'b1, pa(1, 0), 32'h0000_0321);
        rdc(pa(1, 8), 32'hffff_ffc0);
        apb(1'b1, pa(1, 0), 32'h7777_7777);
        rdc(pa(1, 8), 32'hffff_ffff);
        $display("lock and auto mode done");
        apb(1'b0, pa(6, 13'h24), 32'h0);
        apb(1'b1, pa(6, 13'h20), 32'h3);
        apb(1'b1, pa(6, 13'h28), 32'h3);
        ext_level[6][0] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        rdc(pa(6, 13'h24), 32'h2);
        rdc(pa(6, 13'h24), 32'h0);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        ext_level[6][0] <= 1'b0;
        repeat (5) @(posedge clk_sys);
        apb(1'b1, pa(6, 13'h24), 32'h1);
        rdc(pa(6, 13'h24), 32'h0);
        apb(1'b1, pa(6, 13'h20), 32'h0);
        ext_level[6][0] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        $display("interrupt done");
        apb(1'b1, pa(0, 13'h30), 32'h0000_00a5);
        clk_en <= 1'b0;
        apb(1'b1, pa(0, 13'h30), 32'h0000_005a);
        clk_en <= 1'b1;
        rdc(pa(0, 13'h30), 32'h0000_00a5);
        $display("clock enable done");
        test_done;
    end
endmodule : tb
bind port_pin_function_control port_ctrl_asserts chk (.clk_sys, .rst_b,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .crystal_is_sysclk, .pin_oe, .func_sel);
